// ---- rtl/lpm_defs.vh ----
// Purpose: constants for the low-power mode sequencer
// Assumes: apb word index = byte address / 4
// Notes: times in ns, counts derived from subclock ticks
//
// How it works
// - watch exits on reset or wake interrupt
// - watch wake delay: stabilization, or frame-based
// - subactive stops main osc, no conversion
// - subactive cycle divides subclock by 8/4
// - stop/standby in subactive picks watch/active
// - time base gives frame, half is stabilization
// - wake requests issued on frame strobe
// - wake edge counted at second strobe
// - direct transfer goes subactive to active
// - direct flag set only in subactive
// - direct transfer takes stabilization plus up to a frame
// - stop exit restarts; ram flag shows cause
// - reset leaves all; cancel pin only stop
// - asynchronous reset from any state
// - blocked stop/standby acts as no-op
// - wake pin sampled, high then low edge
// - stop bit halts subclock in stop
// - stop bit cleared by software or reset
// - stop in active: watch or stop mode
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH

// register indices
`define IDX_FRAME 8'h0c
`define IDX_LPCTL 8'h20
`define IDX_RAMEN 8'h21
`define IDX_STAT 8'h22
`define IDX_CLKSEL 8'h29

// bit positions
`define LSPD_BIT 0
`define DTRN_BIT 3
`define RAMEN_BIT 3
`define RANGE_BIT 1
`define DIV_BIT 2
`define SSTOP_BIT 3

// timing
`define CLK_NS 8
`define XTAL_NS 30517
`define XTAL_CYC (`XTAL_NS / `CLK_NS)
`define FRAME0_NS 244140
`define FRAME1_NS 15625000
`define FRAME2_NS 62500000
`define FRAME0_XT (`FRAME0_NS / `XTAL_NS)
`define FRAME1_XT (`FRAME1_NS / `XTAL_NS)
`define FRAME2_XT (`FRAME2_NS / `XTAL_NS)
`define SUBDIV_SLOW 8
`define SUBDIV_FAST 4

`endif

// ---- rtl/subclock_timebase.v ----
// Purpose: subclock tick, instruction strobe, frame strobe
// Assumes: pclk 125 MHz, subclock emulated by counting
// Notes: strobes are one pclk wide and xtick aligned
`include "lpm_defs.vh"
module subclock_timebase #(
    parameter XTAL_CYC = `XTAL_CYC
) (
    // system
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // control
    input wire osc_run,
    input wire [1:0] frame_sel,
    input wire div_fast,
    // strobes
    output reg xtick,
    output reg instr_tick,
    output reg frame_strobe
);
    // full-width counts, cut to counter width below
    localparam integer XL = XTAL_CYC - 1;
    localparam integer FL0 = `FRAME0_XT - 1;
    localparam integer FL1 = `FRAME1_XT - 1;
    localparam integer FL2 = `FRAME2_XT - 1;
    localparam integer DS = `SUBDIV_SLOW - 1;
    localparam integer DF = `SUBDIV_FAST - 1;
    localparam [15:0] XLAST = XL[15:0];
    localparam [11:0] F0 = FL0[11:0];
    localparam [11:0] F1 = FL1[11:0];
    localparam [11:0] F2 = FL2[11:0];
    localparam [2:0] DSLOW = DS[2:0];
    localparam [2:0] DFAST = DF[2:0];

    reg [15:0] xcnt;
    reg [11:0] fcnt;
    reg [2:0] icnt;
    wire [11:0] flast;
    wire [2:0] ilast;

    assign flast = (frame_sel == 2'h1) ? F1 : (frame_sel == 2'h2) ? F2 : F0;
    assign ilast = div_fast ? DFAST : DSLOW;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xcnt <= 16'h0000;
            fcnt <= 12'h000;
            icnt <= 3'h0;
            xtick <= 1'b0;
            instr_tick <= 1'b0;
            frame_strobe <= 1'b0;
        end else if (clk_en) begin
            xtick <= 1'b0;
            instr_tick <= 1'b0;
            frame_strobe <= 1'b0;
            if (osc_run) begin
                if (xcnt >= XLAST) begin
                    xcnt <= 16'h0000;
                    xtick <= 1'b1;
                    if (fcnt >= flast) begin
                        fcnt <= 12'h000;
                        frame_strobe <= 1'b1;
                    end else begin
                        fcnt <= fcnt + 12'h001;
                    end
                    if (icnt >= ilast) begin
                        icnt <= 3'h0;
                        instr_tick <= 1'b1;
                    end else begin
                        icnt <= icnt + 3'h1;
                    end
                end else begin
                    xcnt <= xcnt + 16'h0001;
                end
            end
        end
    end
endmodule

// ---- rtl/low_power_mode_sequencer.v ----
// Purpose: low-power mode and clock-select sequencing
// Assumes: cpu core gives instruction strobes and irq state
// Notes: apb slave, zero wait states, word-indexed
//
// Local design decision: the APB interface to the registers.
`include "lpm_defs.vh"
module low_power_mode_sequencer #(
    parameter XTAL_CYC = `XTAL_CYC
) (
    // system
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // cpu core and timer
    input wire stop_instr,
    input wire standby_instr,
    input wire global_interrupt_enable,
    input wire irq_flag_unmasked,
    input wire irq_request,
    input wire timer_a_watch_select,
    input wire timer_a_overflow,
    // pins
    input wire external_wake_pin,
    input wire stop_cancel_pin_n,
    // status
    output reg [2:0] mode,
    output reg main_osc_en,
    output reg sub_osc_en,
    output reg adc_enable,
    output reg cpu_run,
    output reg restart,
    output reg nop_done,
    output reg wake_irq,
    output reg timer_a_irq,
    output wire frame_strobe
);
    localparam [2:0] ST_ACTIVE = 3'h0;
    localparam [2:0] ST_STANDBY = 3'h1;
    localparam [2:0] ST_STOP = 3'h2;
    localparam [2:0] ST_WATCH = 3'h3;
    localparam [2:0] ST_SUBACT = 3'h4;
    localparam [2:0] ST_WAKE = 3'h5;
    localparam [2:0] ST_DIRECT = 3'h6;

    localparam integer SL0 = `FRAME0_XT / 2;
    localparam integer SL1 = `FRAME1_XT / 2;
    localparam integer SL2 = `FRAME2_XT / 2;
    localparam [10:0] S0 = SL0[10:0];
    localparam [10:0] S1 = SL1[10:0];
    localparam [10:0] S2 = SL2[10:0];

    // registers
    reg [1:0] frame_sel;
    reg [1:0] frame_hi;
    reg low_speed_flag;
    reg direct_transfer_flag;
    reg ram_enable_flag;
    reg main_clock_range_bit;
    reg subclock_divider_bit;
    reg subclock_stop_bit;

    // sequencing state
    reg [2:0] next_mode;
    reg [10:0] stab_cnt;
    reg stab_run;
    reg wake_smp;
    reg wake_pend;
    reg ta_pend;

    wire xtick;
    wire instr_tick;
    wire osc_run;
    wire lowpwr;
    wire [7:0] idx;
    wire hit;
    wire wr;
    wire rd_setup;
    wire instr;
    wire blocked;
    wire go_instr;
    wire sample_en;
    wire wake_edge;
    wire lp_issue;
    wire wake_fire;
    wire stab_done;
    wire [10:0] slen;

    assign osc_run = !((mode == ST_STOP) && subclock_stop_bit);

    subclock_timebase #(
        .XTAL_CYC(XTAL_CYC)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .osc_run(osc_run),
        .frame_sel(frame_sel),
        .div_fast(subclock_divider_bit),
        .xtick(xtick),
        .instr_tick(instr_tick),
        .frame_strobe(frame_strobe)
    );

    assign lowpwr = (mode == ST_WATCH) || (mode == ST_SUBACT);

    // apb decode
    assign idx = paddr[9:2];
    assign hit = (paddr[1:0] == 2'h0) &&
                 ((idx == `IDX_FRAME) || (idx == `IDX_LPCTL) ||
                  (idx == `IDX_RAMEN) || (idx == `IDX_STAT) ||
                  (idx == `IDX_CLKSEL));
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign wr = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;

    assign instr = stop_instr || standby_instr;
    assign blocked = !global_interrupt_enable && irq_flag_unmasked;
    assign go_instr = instr && !blocked;

    // sample every cycle or per frame
    assign sample_en = lowpwr ? frame_strobe : 1'b1;
    assign wake_edge = sample_en && wake_smp && !external_wake_pin;

    assign lp_issue = lowpwr && frame_strobe;
    assign wake_fire = lp_issue && (wake_pend || ta_pend);

    assign slen = (frame_sel == 2'h1) ? S1 : (frame_sel == 2'h2) ? S2 : S0;
    assign stab_done = stab_run && xtick && (stab_cnt == 11'h001);

    always @* begin
        next_mode = mode;
        case (mode)
            ST_ACTIVE: begin
                if (go_instr && stop_instr) begin
                    next_mode = timer_a_watch_select ? ST_WATCH : ST_STOP;
                end else if (go_instr) begin
                    next_mode = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (irq_request) begin
                    next_mode = ST_ACTIVE;
                end
            end
            ST_STOP: begin
                if (!stop_cancel_pin_n) begin
                    next_mode = ST_ACTIVE;
                end
            end
            ST_WATCH: begin
                if (wake_fire) begin
                    next_mode = low_speed_flag ? ST_SUBACT : ST_WAKE;
                end
            end
            ST_SUBACT: begin
                if (go_instr) begin
                    if (!low_speed_flag && direct_transfer_flag) begin
                        next_mode = ST_DIRECT;
                    end else begin
                        next_mode = ST_WATCH;
                    end
                end
            end
            ST_WAKE: begin
                if (stab_done) begin
                    next_mode = ST_ACTIVE;
                end
            end
            ST_DIRECT: begin
                if (stab_done) begin
                    next_mode = ST_ACTIVE;
                end
            end
            default: begin
                next_mode = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ST_ACTIVE;
            main_osc_en <= 1'b1;
            sub_osc_en <= 1'b1;
            adc_enable <= 1'b1;
            cpu_run <= 1'b0;
            restart <= 1'b0;
            nop_done <= 1'b0;
        end else if (clk_en) begin
            mode <= next_mode;
            main_osc_en <= (next_mode == ST_ACTIVE) ||
                           (next_mode == ST_STANDBY) ||
                           (next_mode == ST_WAKE) ||
                           (next_mode == ST_DIRECT);
            adc_enable <= (next_mode == ST_ACTIVE) ||
                          (next_mode == ST_STANDBY);
            sub_osc_en <= !((next_mode == ST_STOP) && subclock_stop_bit);
            cpu_run <= (next_mode == ST_ACTIVE) ||
                       ((next_mode == ST_SUBACT) && instr_tick);
            restart <= (mode == ST_STOP) && !stop_cancel_pin_n;
            nop_done <= instr && blocked &&
                        ((mode == ST_ACTIVE) || (mode == ST_SUBACT));
        end
    end

    // stabilization counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt <= 11'h000;
            stab_run <= 1'b0;
        end else if (clk_en) begin
            if ((mode != ST_WAKE) && (next_mode == ST_WAKE)) begin
                stab_cnt <= slen;
                stab_run <= 1'b1;
            end else if ((mode != ST_DIRECT) && (next_mode == ST_DIRECT)) begin
                stab_cnt <= slen;
                stab_run <= 1'b0;
            end else if ((mode == ST_DIRECT) && !stab_run && frame_strobe) begin
                stab_run <= 1'b1;
            end else if (stab_done) begin
                stab_cnt <= 11'h000;
                stab_run <= 1'b0;
            end else if (stab_run && xtick) begin
                stab_cnt <= stab_cnt - 11'h001;
            end
        end
    end

    // wake pin and timer requests
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_smp <= 1'b0;
            wake_pend <= 1'b0;
            ta_pend <= 1'b0;
            wake_irq <= 1'b0;
            timer_a_irq <= 1'b0;
        end else if (clk_en) begin
            if (sample_en) begin
                wake_smp <= external_wake_pin;
            end
            if (lowpwr) begin
                wake_pend <= (wake_pend && !lp_issue) || wake_edge;
                ta_pend <= (ta_pend && !lp_issue) || timer_a_overflow;
                wake_irq <= lp_issue && wake_pend;
                timer_a_irq <= lp_issue && ta_pend;
            end else begin
                wake_pend <= 1'b0;
                ta_pend <= 1'b0;
                wake_irq <= wake_edge;
                timer_a_irq <= timer_a_overflow;
            end
        end
    end

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sel <= 2'h0;
            frame_hi <= 2'h0;
            low_speed_flag <= 1'b0;
            direct_transfer_flag <= 1'b0;
            ram_enable_flag <= 1'b0;
            main_clock_range_bit <= 1'b0;
            subclock_divider_bit <= 1'b0;
            subclock_stop_bit <= 1'b0;
        end else if (clk_en) begin
            if (wr && (idx == `IDX_FRAME)) begin
                frame_sel <= pwdata[1:0];
                frame_hi <= pwdata[3:2];
            end
            if (wr && (idx == `IDX_LPCTL)) begin
                low_speed_flag <= pwdata[`LSPD_BIT];
            end
            if (mode == ST_ACTIVE) begin
                direct_transfer_flag <= 1'b0;
            end else if (wr && (idx == `IDX_LPCTL) && (mode == ST_SUBACT)) begin
                direct_transfer_flag <= pwdata[`DTRN_BIT];
            end
            if ((mode == ST_STOP) && !stop_cancel_pin_n) begin
                ram_enable_flag <= 1'b1;
            end else if (wr && (idx == `IDX_RAMEN)) begin
                ram_enable_flag <= pwdata[`RAMEN_BIT];
            end
            // stop bit only software or reset
            if (wr && (idx == `IDX_CLKSEL)) begin
                main_clock_range_bit <= pwdata[`RANGE_BIT];
                subclock_divider_bit <= pwdata[`DIV_BIT];
                subclock_stop_bit <= pwdata[`SSTOP_BIT];
            end
        end
    end

    // read data captured in setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            if (rd_setup) begin
                prdata <= 32'h00000000;
                case (idx)
                    `IDX_LPCTL: begin
                        prdata[`LSPD_BIT] <= low_speed_flag;
                        prdata[`DTRN_BIT] <= direct_transfer_flag;
                    end
                    `IDX_RAMEN: begin
                        prdata[`RAMEN_BIT] <= ram_enable_flag;
                    end
                    `IDX_STAT: begin
                        prdata[2:0] <= mode;
                    end
                    `IDX_CLKSEL: begin
                        prdata[`RANGE_BIT] <= main_clock_range_bit;
                        prdata[`DIV_BIT] <= subclock_divider_bit;
                        prdata[`SSTOP_BIT] <= subclock_stop_bit;
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end
endmodule

// ---- sim/lpm_properties.sv ----
// Purpose: port-level properties of the mode sequencer
// Assumes: sees only the top-level ports
// Notes: bound into every sequencer instance
module lpm_properties #(
    parameter XTAL_CYC = 4
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // cpu core and pins
    input wire logic stop_instr,
    input wire logic standby_instr,
    input wire logic global_interrupt_enable,
    input wire logic irq_flag_unmasked,
    input wire logic timer_a_watch_select,
    input wire logic stop_cancel_pin_n,
    // status
    input wire logic [2:0] mode,
    input wire logic main_osc_en,
    input wire logic sub_osc_en,
    input wire logic adc_enable,
    input wire logic restart,
    input wire logic nop_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire blocked = !global_interrupt_enable && irq_flag_unmasked;
    wire go = clk_en && !blocked && stop_instr;

    watch_entry_a: assert property (
        mode == 3'd0 && go && timer_a_watch_select |=> mode == 3'd3)
        else $error("stop in active missed watch mode");
    stop_entry_a: assert property (
        mode == 3'd0 && go && !timer_a_watch_select |=> mode == 3'd2)
        else $error("stop in active missed stop mode");
    blocked_nop_a: assert property (
        mode inside {3'd0, 3'd4} && (stop_instr || standby_instr) && blocked && clk_en
        |=> nop_done && mode == $past(mode))
        else $error("blocked instruction changed mode");
    cancel_exit_a: assert property (
        mode == 3'd2 && !stop_cancel_pin_n && clk_en |=> mode == 3'd0 ##[0:1] restart)
        else $error("cancel pin did not restart from stop");
    active_hold_a: assert property (
        mode == 3'd0 && !stop_instr && !standby_instr |=> mode == 3'd0)
        else $error("active mode left without instruction");
    low_clock_a: assert property (
        mode inside {3'd3, 3'd4} |-> !main_osc_en && !adc_enable)
        else $error("main oscillator or converter on in low power");
    stab_osc_a: assert property (
        mode inside {3'd5, 3'd6} |-> main_osc_en)
        else $error("main oscillator off while stabilizing");
    subclock_run_a: assert property (
        mode != 3'd2 |-> sub_osc_en)
        else $error("subclock stopped outside stop mode");
endmodule

bind low_power_mode_sequencer lpm_properties #(.XTAL_CYC(XTAL_CYC)) chk (.*);

// ---- sim/cpu_core_model.sv ----
// Purpose: cpu core, timer a and wake pin stand-in
// Assumes: instructions issue only on a cpu_run cycle
// Notes: driven through its tasks by the bench
module cpu_core_model (
    // clock and status
    input wire logic pclk,
    input wire logic cpu_run,
    // instructions and events
    output logic stop_instr,
    output logic standby_instr,
    output logic timer_a_overflow,
    output logic external_wake_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        stop_instr = 0;
        standby_instr = 0;
        timer_a_overflow = 0;
        external_wake_pin = 1;
    end

    task automatic exec(input logic standby_instruction);
        @(posedge pclk iff cpu_run === 1'b1);
        stop_instr <= !standby_instruction;
        standby_instr <= standby_instruction;
        @(posedge pclk);
        stop_instr <= 0;
        standby_instr <= 0;
    endtask

    task automatic overflow();
        timer_a_overflow <= 1;
        @(posedge pclk);
        timer_a_overflow <= 0;
    endtask

    task automatic wake_level(input logic lv, input int hold);
        repeat (hold) @(posedge pclk);
        external_wake_pin <= lv;
    endtask
endmodule

// ---- sim/low_power_mode_sequencer_tb.sv ----
// Purpose: self-checking bench for the mode sequencer
// Assumes: subclock tick shortened to four pclk cycles
// Notes: frame and stabilization counts derived from XC
`include "lpm_defs.vh"
module low_power_mode_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int XC = 4;
    localparam int FR = `FRAME0_XT * XC;
    localparam int H = FR / 2;
    localparam int TK [4] = '{`FRAME0_XT, `FRAME1_XT, `FRAME2_XT, `FRAME0_XT};
    localparam logic [9:0] A_FRM = {`IDX_FRAME, 2'b00};
    localparam logic [9:0] A_CTL = {`IDX_LPCTL, 2'b00};
    localparam logic [9:0] A_RAM = {`IDX_RAMEN, 2'b00};
    localparam logic [9:0] A_STA = {`IDX_STAT, 2'b00};
    localparam logic [9:0] A_CLK = {`IDX_CLKSEL, 2'b00};
    localparam logic [9:0] REGS [5] = '{A_FRM, A_CTL, A_RAM, A_STA, A_CLK};
    logic pclk, presetn, clk_en, psel, penable, pwrite, irq_request;
    logic global_interrupt_enable, irq_flag_unmasked, timer_a_watch_select;
    logic stop_cancel_pin_n;
    logic [9:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata;
    wire [2:0] mode;
    wire pready, pslverr, stop_instr, standby_instr, timer_a_overflow, external_wake_pin;
    wire main_osc_en, sub_osc_en, adc_enable, cpu_run, restart, nop_done;
    wire wake_irq, timer_a_irq, frame_strobe;
    int mismatches, check_count, n, m;

    low_power_mode_sequencer #(.XTAL_CYC(XC)) DUT (.*);
    cpu_core_model cpu (.pclk(pclk), .cpu_run(cpu_run), .stop_instr(stop_instr),
        .standby_instr(standby_instr), .timer_a_overflow(timer_a_overflow),
        .external_wake_pin(external_wake_pin));

    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        // idle edge so the next setup never re-drives in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(0, a, 0, r, e);
        check(r, x);
        check(e, xe);
    endtask

    task automatic wait_mode(input logic [2:0] m, input int lim, output int c);
        c = 0;
        while (mode !== m && c < lim) begin
            @(posedge pclk);
            c++;
        end
        if (mode !== m) check(mode, m);
    endtask

    task automatic run_gap(input logic frm, output int g);
        g = 1;
        while ((frm ? frame_strobe : cpu_run) !== 1'b1) @(posedge pclk);
        @(posedge pclk);
        while ((frm ? frame_strobe : cpu_run) !== 1'b1) begin
            @(posedge pclk);
            g++;
        end
    endtask

    task automatic irq_state(input logic ie, input logic fl);
        global_interrupt_enable <= ie;
        irq_flag_unmasked <= fl;
    endtask

    task automatic done(input string name);
        $display("test %0s finished", name);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        clk_en = 1;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        irq_request = 0;
        irq_state(1, 0);
        timer_a_watch_select = 1;
        stop_cancel_pin_n = 1;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (REGS[i]) rd(REGS[i], 0, 0);
        rd(10'h3fc, 0, 1);
        wr(A_CTL, 9);
        rd(A_CTL, 1, 0);
        wr(A_FRM, 15);
        rd(A_FRM, 0, 0);
        wr(A_CLK, 14);
        rd(A_CLK, 14, 0);
        done("registers");
        irq_state(0, 1);
        cpu.exec(0);
        @(posedge pclk);
        check(nop_done, 1);
        check(mode, 0);
        irq_state(1, 0);
        cpu.exec(1);
        wait_mode(1, 8, n);
        irq_request <= 1;
        wait_mode(0, 8, n);
        irq_request <= 0;
        wr(A_CLK, 10);
        timer_a_watch_select <= 0;
        cpu.exec(0);
        wait_mode(2, 8, n);
        @(posedge pclk);
        check(sub_osc_en, 0);
        clk_en <= 0;
        stop_cancel_pin_n <= 0;
        repeat (4) @(posedge pclk);
        check(mode, 2);
        clk_en <= 1;
        wait_mode(0, 8, n);
        check(restart, 1);
        stop_cancel_pin_n <= 1;
        rd(A_RAM, 8, 0);
        rd(A_CLK, 10, 0);
        wr(A_CLK, 2);
        wr(A_CTL, 0);
        done("stop");
        timer_a_watch_select <= 1;
        for (int s = 0; s < 4; s++) begin
            wr(A_FRM, s);
            cpu.exec(0);
            wait_mode(3, 8, n);
            cpu.overflow();
            wait_mode(5, 4 * TK[s] * XC, n);
            check(timer_a_irq, 1);
            wait_mode(0, 4 * TK[s] * XC, n);
            check(n, TK[s] / 2 * XC);
        end
        wr(A_FRM, 0);
        run_gap(1, n);
        check(n, FR);
        cpu.exec(0);
        wait_mode(3, 8, n);
        cpu.wake_level(0, 2 * FR);
        wait_mode(5, 4 * FR, n);
        check(wake_irq, 1);
        wait_mode(0, 2 * FR, m);
        check(n + m >= FR + H && n + m <= 2 * FR + H + 2, 1);
        cpu.wake_level(1, 0);
        done("watch");
        for (int d = 0; d < 2; d++) begin
            wr(A_CLK, 2 + 4 * d);
            wr(A_CTL, 1);
            cpu.exec(0);
            wait_mode(3, 8, n);
            cpu.overflow();
            wait_mode(4, 2 * FR, n);
            check(main_osc_en, 0);
            run_gap(0, n);
            check(n, (d ? 4 : 8) * XC);
            wr(A_CTL, d ? 0 : 8);
            rd(A_CTL, d ? 0 : 8, 0);
            cpu.exec(d);
            wait_mode(d ? 3 : 6, 8 * XC, n);
            if (d) begin
                cpu.overflow();
                wait_mode(5, 2 * FR, n);
            end
            wait_mode(0, 2 * FR, n);
            check(d ? n == H : n > H && n <= FR + H, 1);
            rd(A_CTL, 0, 0);
        end
        done("subactive");
        cpu.exec(0);
        wait_mode(3, 8, n);
        presetn <= 0;
        #1 check(mode, 0);
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(A_RAM, 0, 0);
        done("reset");
        tally_and_finish();
    end
endmodule
